// ==== csd_defs.vh ====
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define CSD_ADDR_W          6
`define CSD_REG_DELIM_ADDR  6'h0B
`define CSD_DELIM_RESET     8'hA7

// ---------------------------------------------------------------
// symbol sizes per modulation
// ---------------------------------------------------------------
`define CSD_BPSK_SYMS       4'h8
`define CSD_OQPSK_SYMS      4'h2
`define CSD_BPSK_SYM_BITS   3'h1
`define CSD_OQPSK_SYM_BITS  3'h4

`endif

// ==== csd_shift.v ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// lsb-first octet shifter: 1 or 4 bits per symbol
// ---------------------------------------------------------------
module csd_shift (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       load,
    input  wire [7:0] load_val,
    input  wire       shift,
    input  wire       nib_mode,
    input  wire [3:0] sym_in,
    output wire [7:0] octet,
    output wire [3:0] sym_out
);
    reg [7:0] sr_r;
    reg [7:0] sr_nxt;

    always @* begin
        sr_nxt = sr_r;
        if (load) begin
            sr_nxt = load_val;
        end else if (shift) begin
            // receive fills from top, transmit drains from bottom
            if (nib_mode)
                sr_nxt = {sym_in, sr_r[7:4]};
            else
                sr_nxt = {sym_in[0], sr_r[7:1]};
        end
    end

    always @(posedge sys_clk) begin
        if (srst)
            sr_r <= 8'h00;
        else
            sr_r <= sr_nxt;
    end

    assign octet   = sr_r;
    assign sym_out = nib_mode ? sr_r[3:0] : {3'h0, sr_r[0]};
endmodule // csd_shift

`default_nettype wire

// ==== csd_framer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.vh"

module csd_framer (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [5:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       oqpsk_mode,
    input  wire       rx_search,
    input  wire       rx_sym_vld,
    input  wire [3:0] rx_sym,
    input  wire       rx_phr_ok,
    input  wire       rx_phr_bad,
    input  wire       rx_start_en,
    input  wire       tx_pre_done,
    input  wire       tx_sym_rdy,
    output reg        tx_sym_vld,
    output reg  [3:0] tx_sym,
    output reg        tx_delim_done,
    output reg        rx_synced,
    output reg        rx_start_evt
);
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_TX   = 4'b0010;
    localparam [3:0] ST_RX   = 4'b0100;
    localparam [3:0] ST_PHR  = 4'b1000;

    reg  [7:0] start_delimiter_value_r;
    reg  [7:0] frame_delim_r;
    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg  [3:0] sym_cnt_r;
    reg  [3:0] sym_cnt_nxt;
    reg        nib_r;
    reg        sh_load;
    reg        sh_shift;
    wire [7:0] sh_octet;
    wire [7:0] rx_cand;
    wire       rx_last;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function [3:0] syms_per_octet;
        input q;
        begin
            syms_per_octet = q ? `CSD_OQPSK_SYMS : `CSD_BPSK_SYMS;
        end
    endfunction

    function hits_delim;
        input [5:0] a;
        begin
            hits_delim = a == `CSD_REG_DELIM_ADDR;
        end
    endfunction

    function [3:0] lsb_sym;
        input       q;
        input [7:0] v;
        begin
            // first symbol out carries the lowest bits
            lsb_sym = q ? v[3:0] : {3'h0, v[0]};
        end
    endfunction

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (srst) begin
            start_delimiter_value_r <= `CSD_DELIM_RESET;
            reg_rdata               <= 8'h00;
        end else begin
            if (reg_wr && hits_delim(reg_addr))
                start_delimiter_value_r <= reg_wdata;
            // low-nibble-zero values still accepted; software's care
            if (reg_rd && hits_delim(reg_addr))
                reg_rdata <= start_delimiter_value_r;
            else if (reg_rd)
                reg_rdata <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // octet shifter
    // ---------------------------------------------------------------
    csd_shift u_shift (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .load     (sh_load),
        .load_val (start_delimiter_value_r),
        .shift    (sh_shift),
        .nib_mode (nib_r),
        .sym_in   (rx_sym),
        .octet    (sh_octet),
        .sym_out  ()
    );

    // ---------------------------------------------------------------
    // receive window
    // ---------------------------------------------------------------
    // sliding window: once a full octet of symbols is in, match at any symbol boundary while searching
    assign rx_cand = nib_r ? {rx_sym, sh_octet[7:4]}
                           : {rx_sym[0], sh_octet[7:1]};
    assign rx_last = sym_cnt_r == 4'h1;

    // ---------------------------------------------------------------
    // control
    // ---------------------------------------------------------------
    always @* begin
        state_nxt   = state_r;
        sym_cnt_nxt = sym_cnt_r;
        sh_load     = 1'b0;
        sh_shift    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (tx_pre_done) begin
                    // snapshot so later writes wait a frame
                    sh_load     = 1'b1;
                    sym_cnt_nxt = syms_per_octet(oqpsk_mode);
                    state_nxt   = ST_TX;
                end else if (rx_search) begin
                    sym_cnt_nxt = syms_per_octet(oqpsk_mode);
                    state_nxt   = ST_RX;
                end
            end
            ST_TX: begin
                if (tx_sym_rdy) begin
                    sh_shift    = 1'b1;
                    sym_cnt_nxt = sym_cnt_r - 4'h1;
                    if (rx_last)
                        state_nxt = ST_IDLE;
                end
            end
            ST_RX: begin
                if (!rx_search) begin
                    state_nxt = ST_IDLE;
                end else if (rx_sym_vld) begin
                    sh_shift = 1'b1;
                    if (sym_cnt_r != 4'h0)
                        sym_cnt_nxt = sym_cnt_r - 4'h1;
                    // other delimiters keep the search going
                    if ((sym_cnt_r <= 4'h1) && rx_cand == frame_delim_r)
                        state_nxt = ST_PHR;
                end
            end
            ST_PHR: begin
                if (rx_phr_ok || rx_phr_bad || !rx_search)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            state_r       <= ST_IDLE;
            sym_cnt_r     <= 4'h0;
            nib_r         <= 1'b0;
            frame_delim_r <= `CSD_DELIM_RESET;
        end else begin
            state_r   <= state_nxt;
            sym_cnt_r <= sym_cnt_nxt;
            // snapshot only while idle, so a write never splits a frame
            if (state_r == ST_IDLE) begin
                nib_r         <= oqpsk_mode;
                frame_delim_r <= start_delimiter_value_r;
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit outputs
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (srst) begin
            tx_sym_vld    <= 1'b0;
            tx_sym        <= 4'h0;
            tx_delim_done <= 1'b0;
        end else begin
            tx_sym_vld    <= state_nxt == ST_TX;
            // symbol must hold while the consumer stalls
            if (sh_load) begin
                tx_sym <= lsb_sym(oqpsk_mode, start_delimiter_value_r);
            end else if (state_r == ST_TX && tx_sym_rdy) begin
                tx_sym <= nib_r ? sh_octet[7:4] : {3'h0, sh_octet[1]};
            end
            tx_delim_done <= state_r == ST_TX && tx_sym_rdy && rx_last;
        end
    end

    // ---------------------------------------------------------------
    // receive outputs
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (srst) begin
            rx_synced    <= 1'b0;
            rx_start_evt <= 1'b0;
        end else begin
            // byte lock only: the octet itself is not handed on
            rx_synced    <= state_r == ST_RX && state_nxt == ST_PHR;
            rx_start_evt <= state_r == ST_PHR && rx_phr_ok
                            && rx_start_en;
        end
    end
endmodule // csd_framer

`default_nettype wire

// ==== csd_framer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module csd_framer_sva (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       oqpsk_mode,
    input wire logic       rx_phr_ok,
    input wire logic       rx_start_en,
    input wire logic       tx_pre_done,
    input wire logic       tx_sym_rdy,
    input wire logic       tx_sym_vld,
    input wire logic       tx_delim_done,
    input wire logic       rx_synced,
    input wire logic       rx_start_evt,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] rx_sym,
    input wire logic [3:0] tx_sym
);
    logic [7:0] sh_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // mirror of the register, so frames can be judged
    always @(posedge sys_clk)
        if (srst)
            sh_r <= 8'hA7;
        else if (reg_wr && reg_addr == 6'h0B)
            sh_r <= reg_wdata;
    sequence oq_tx_s;
        tx_pre_done && oqpsk_mode ##1 tx_sym_rdy [*2];
    endsequence
    sequence bp_tx_s;
        tx_pre_done && !oqpsk_mode ##1 tx_sym_rdy [*8];
    endsequence
    rd_unmap_a: assert property (reg_rd && reg_addr != 6'h0B
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    rd_value_a: assert property (reg_rd && reg_addr == 6'h0B
        |=> reg_rdata == $past(sh_r)) else $error("register read");
    tx_start_a: assert property (tx_pre_done
        |=> tx_sym_vld) else $error("late delimiter");
    tx_lsb_a: assert property (tx_pre_done && oqpsk_mode
        |=> tx_sym == $past(sh_r[3:0])) else $error("first symbol");
    oq_len_a: assert property (oq_tx_s
        |=> tx_delim_done && !tx_sym_vld) else $error("qpsk length");
    bp_len_a: assert property (bp_tx_s
        |=> tx_delim_done && !tx_sym_vld) else $error("bpsk length");
    rx_match_a: assert property (rx_synced && oqpsk_mode
        |-> $past(rx_sym) == sh_r[7:4]) else $error("wrong sync");
    evt_cause_a: assert property (rx_start_evt
        |-> $past(rx_phr_ok && rx_start_en)) else $error("stray start");
endmodule // csd_framer_sva
bind csd_framer csd_framer_sva u_sva (.*);
`default_nettype wire

// ==== csd_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module csd_node (
    input  wire logic       sys_clk,
    input  wire logic       oqpsk_mode,
    input  wire logic       tx_sym_vld,
    input  wire logic [3:0] tx_sym,
    output var  logic       tx_sym_rdy = 1'h0,
    output var  logic       rx_sym_vld = 1'h0,
    output var  logic [3:0] rx_sym = 4'h0,
    output var  logic [7:0] got = 8'h00
);
    logic slow = 1'h0;
    logic tog = 1'h0;
    // alternate-cycle stall tests the held request
    always @(negedge sys_clk) begin
        tog <= !tog;
        tx_sym_rdy <= tx_sym_vld && !(slow && tog);
    end
    always @(posedge sys_clk)
        if (tx_sym_vld && tx_sym_rdy)
            got <= oqpsk_mode ? {tx_sym, got[7:4]}
                              : {tx_sym[0], got[7:1]};
    task automatic send(input logic [7:0] v);
        int i;
        for (i = 0; i < (oqpsk_mode ? 2 : 8); i++) begin
            @(negedge sys_clk);
            rx_sym_vld = 1'h1;
            rx_sym = oqpsk_mode ? v[4*i+:4] : {~rx_sym[3:1], v[i]};
            @(negedge sys_clk);
            rx_sym_vld = 1'h0;
            // stale symbol inverted, never left looking valid
            rx_sym = ~rx_sym;
        end
    endtask
endmodule // csd_node
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic       oqpsk_mode = 1'h0, rx_search = 1'h0, rx_phr_ok = 1'h0;
    logic       rx_phr_bad = 1'h0, rx_start_en = 1'h0, tx_pre_done = 1'h0;
    logic       tx_sym_rdy, tx_sym_vld, tx_delim_done, rx_synced;
    logic       rx_start_evt, rx_sym_vld;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, got;
    logic [3:0] rx_sym, tx_sym;
    int         n_mismatch = 0, check_count = 0, n_sync = 0, n_evt = 0;
    csd_framer uut (.*);
    csd_node node (.*);
    always #5 sys_clk = !sys_clk;
    always @(posedge sys_clk) begin
        n_sync <= n_sync + int'(rx_synced);
        n_evt <= n_evt + int'(rx_start_evt);
    end
    task automatic chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
        @(negedge sys_clk);
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        {reg_rd, reg_addr} = {1'h1, a};
        @(negedge sys_clk);
        reg_rd = 1'h0;
        chk("rdata", reg_rdata, e);
    endtask
    // a write lands while the frame is on the air
    task automatic tx_frame(input logic s, input logic [7:0] nw, e);
        int i;
        node.slow = s;
        @(negedge sys_clk);
        tx_pre_done = 1'h1;
        @(negedge sys_clk);
        {tx_pre_done, reg_wr, reg_addr, reg_wdata} = {2'h1, 6'h0B, nw};
        @(negedge sys_clk);
        reg_wr = 1'h0;
        for (i = 0; i < 40 && tx_delim_done !== 1'h1; i++)
            @(negedge sys_clk);
        chk("tx octet", got, e);
        chk("tx done", {7'h00, tx_delim_done}, 8'h01);
    endtask
    task automatic t_regs;
        rd(6'h0B, 8'hA7);
        wr(6'h0B, 8'h5C); // low nibble kept nonzero
        rd(6'h0B, 8'h5C);
        wr(6'h0C, 8'h11);
        rd(6'h0C, 8'h00);
        rd(6'h0B, 8'h5C);
        $display("test regs done");
    endtask
    task automatic t_tx(input logic m);
        oqpsk_mode = m;
        tx_frame(1'h1, 8'hA3, 8'h5C);
        tx_frame(1'h0, 8'h5C, 8'hA3);
        $display("test tx done");
    endtask
    task automatic t_rx(input logic m);
        int s0 = n_sync;
        int e0 = n_evt;
        {oqpsk_mode, rx_start_en, rx_search} = {m, m, 1'h1};
        node.send(8'hFF);
        // a phr with no delimiter match must stay silent
        rx_phr_ok = 1'h1;
        @(negedge sys_clk);
        rx_phr_ok = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk("sync other", 8'(n_sync - s0), 8'h00);
        chk("start other", 8'(n_evt - e0), 8'h00);
        node.send(8'h5C);
        repeat (2) @(negedge sys_clk);
        chk("sync", 8'(n_sync - s0), 8'h01);
        rx_phr_bad = 1'h1;
        @(negedge sys_clk);
        rx_phr_bad = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk("start bad phr", 8'(n_evt - e0), 8'h00);
        node.send(8'h5C);
        repeat (2) @(negedge sys_clk);
        chk("sync again", 8'(n_sync - s0), 8'h02);
        rx_phr_ok = 1'h1;
        @(negedge sys_clk);
        rx_phr_ok = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk("rx start", 8'(n_evt - e0), {7'h00, m});
        // the search must drop for an edge so the next mode is latched
        rx_search = 1'h0;
        @(negedge sys_clk);
        $display("test rx done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        srst = 1'h0;
        t_regs;
        t_tx(1'h0);
        t_tx(1'h1);
        t_rx(1'h0);
        t_rx(1'h1);
        give_verdict;
    end
    // tests need well under 300 cycles
    initial begin
        #20000;
        n_mismatch++;
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
